// File: nvc_array.sv
// 64-byte EEPROM cell array, one row written per programming cycle
// Assumes the controller raises we_i for one cycle at the end of a cycle
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defines.svh"

module nvc_array
    import nvc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Row write port
    input wire logic we_i,
    input wire logic [2:0] row_i,
    input wire logic [63:0] data_i,
    input wire logic [7:0] mask_i,
    // Read port
    input wire logic [5:0] raddr_i,
    output logic [7:0] rdata_o
);

    nvc_mem_t q;
    nvc_mem_t d;

    // Only masked bytes of the addressed row change
    for (genvar i = 0; i < `NVC_BYTES; i++)
    begin : g_cell
        assign d[i] = (we_i && row_i == 3'(i / 8) && mask_i[i % 8]) ?
                      data_i[(i % 8) * 8 +: 8] : q[i];
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= {`NVC_BYTES{`NVC_ERASED}};
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata_o = q[raddr_i];

endmodule

`default_nettype wire

// File: nvc_cpu_model.sv
// CPU core model: data-space reads and writes toward the controller
// Assumes the bench calls its tasks; bus lines change at falling edges
`timescale 1ns/1ps
`default_nettype none

module nvc_cpu_model
(
    // Clock
    input wire logic clk_i,
    // Data-space bus
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    // Answer and status
    input wire logic [7:0] rdata_i,
    input wire logic rhit_i,
    input wire logic busy_i
);
    logic [7:0] seen_data;
    logic seen_hit;

    initial
    begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // Released bus shows the inverted last value
    task automatic drop_bus();
        addr_o = ~addr_o;
        wdata_o = ~wdata_o;
    endtask

    // Bank page is changed by any bank write, armed or not
    task automatic cpu_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        drop_bus();
    endtask

    // While armed, rows other than the latched row read back as erased
    task automatic cpu_read(input logic [7:0] a);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        seen_data = rdata_i;
        seen_hit = rhit_i;
        drop_bus();
    endtask

    // Poll busy before an access
    task automatic wait_idle();
        for (int i = 0; i < 100 && busy_i !== 1'b0; i++)
        begin
            @(negedge clk_i);
        end
    endtask
endmodule

`default_nettype wire

// File: nvc_ctrl.sv
// Data EEPROM write controller: control register, paging and cycle timing
// Assumes CPU data-space strobes are synchronous to clk_i
//
// Functional notes
// - Armed parallel mode latches row and data
// - Armed: only the latched row is reachable
// - Arming clears all eight row latches
// - Start programs only bytes written after arming
// - Arm bit clears at end of cycle
// - Start needs enable and arm, else ignored
// - Start bit clears when programming completes
// - Row is eight bytes; low three bits select
// - Clearing arm abandons row, contents unchanged
// - Busy flag set while programming
// - Access while busy aborted; cycle completes
// - Program enable gates every write cycle
// - Standby bit disables the EEPROM
// - Halt disables the EEPROM
// - Control resets to zero; reserved bits zero
// - Unprogrammed bytes read as erased value
// - Control writes ignored while busy
// - Bank bit 0 maps EEPROM page 0
// - Byte mode programs exactly one byte
`timescale 1ns/1ps
`default_nettype none
`include "nvc_defines.svh"

module nvc_ctrl
    import nvc_pkg::*;
#(
    parameter int PROG_CYCLES = `NVC_PROG_TIME_NS / `NVC_CLK_PERIOD_NS
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // CPU data-space access
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    // Core power state
    input wire logic halt_i,
    // Read answer and status
    output logic [7:0] rdata_o,
    output logic rhit_o,
    output logic busy_o,
    output logic off_o
);

    nvc_ctl_t q;
    nvc_ctl_t d;

    logic lat_clr;
    logic lat_ld;
    logic lat_vld;
    logic [2:0] lat_row;
    logic [63:0] lat_data;
    logic [7:0] lat_mask;
    logic arr_we;
    logic [2:0] arr_row;
    logic [63:0] arr_data;
    logic [7:0] arr_mask;
    logic [7:0] arr_rd;
    logic ctrl_wr;
    logic bank_wr;
    logic eep_sel;
    logic eep_ok;
    logic row_ok;
    logic prog_done;

    nvc_row_latch u_latch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clr_i(lat_clr),
        .ld_i(lat_ld),
        .addr_i(addr_i[5:0]),
        .data_i(wdata_i),
        .vld_o(lat_vld),
        .row_o(lat_row),
        .data_o(lat_data),
        .mask_o(lat_mask)
    );

    nvc_array u_array (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(arr_we),
        .row_i(arr_row),
        .data_i(arr_data),
        .mask_i(arr_mask),
        .raddr_i(addr_i[5:0]),
        .rdata_o(arr_rd)
    );

    // Address decode
    assign ctrl_wr = wr_i && (addr_i == `NVC_CTRL_ADDR);
    assign bank_wr = wr_i && (addr_i == `NVC_BANK_ADDR);
    assign eep_sel = (addr_i[7:6] == `NVC_WIN_TOP) && q.page0;
    assign eep_ok = eep_sel && !q.standby && !halt_i;
    assign row_ok = !lat_vld || (lat_row == addr_i[5:3]);
    assign prog_done = (q.state == NVC_PROG) && (q.cnt == 16'(PROG_CYCLES - 1));

    // Array write port: latched row in parallel mode, one byte otherwise
    always_comb
    begin
        arr_we = prog_done;
        if (q.par)
        begin
            arr_row = lat_row;
            arr_data = lat_data;
            arr_mask = lat_mask;
        end
        else
        begin
            arr_row = q.saddr[5:3];
            arr_data = {8{q.sdata}};
            arr_mask = 8'h01 << q.saddr[2:0];
        end
    end

    always_comb
    begin
        d = q;
        d.rhit = 1'b0;
        d.rdata = 8'h00;
        lat_clr = 1'b0;
        lat_ld = 1'b0;
        if (bank_wr)
        begin
            d.page0 = wdata_i[`NVC_BIT_PAGE0];
        end
        case (q.state)
            NVC_IDLE:
            begin
                if (ctrl_wr)
                begin
                    d.en = wdata_i[`NVC_BIT_EN];
                    d.standby = wdata_i[`NVC_BIT_STBY];
                    d.arm = wdata_i[`NVC_BIT_ARM];
                    if (wdata_i[`NVC_BIT_ARM] != q.arm)
                    begin
                        lat_clr = 1'b1;
                    end
                    if (wdata_i[`NVC_BIT_START] && wdata_i[`NVC_BIT_EN] &&
                        wdata_i[`NVC_BIT_ARM] && q.arm)
                    begin
                        d.start = 1'b1;
                        d.par = 1'b1;
                        d.cnt = 16'h0000;
                        d.state = NVC_PROG;
                    end
                end
                else if (wr_i && eep_ok)
                begin
                    if (q.arm)
                    begin
                        lat_ld = row_ok;
                    end
                    else if (q.en)
                    begin
                        d.par = 1'b0;
                        d.saddr = addr_i[5:0];
                        d.sdata = wdata_i;
                        d.cnt = 16'h0000;
                        d.state = NVC_PROG;
                    end
                end
            end
            NVC_PROG:
            begin
                d.cnt = q.cnt + 16'h0001;
                if (prog_done)
                begin
                    d.state = NVC_IDLE;
                    if (q.par)
                    begin
                        d.arm = 1'b0;
                        d.start = 1'b0;
                        lat_clr = 1'b1;
                    end
                end
            end
            default:
            begin
                d.state = NVC_IDLE;
            end
        endcase
        // Read answers
        if (rd_i && addr_i == `NVC_CTRL_ADDR)
        begin
            d.rhit = 1'b1;
            d.rdata = `NVC_CTRL_RESET;
            d.rdata[`NVC_BIT_BUSY] = q.busy;
        end
        else if (rd_i && eep_sel)
        begin
            d.rhit = 1'b1;
            if (eep_ok && q.state == NVC_IDLE && (!q.arm || row_ok))
            begin
                d.rdata = arr_rd;
            end
            else
            begin
                d.rdata = `NVC_ERASED;
            end
        end
        d.busy = (d.state == NVC_PROG);
        d.off = d.standby || halt_i;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata_o = q.rdata;
    assign rhit_o = q.rhit;
    assign busy_o = q.busy;
    assign off_o = q.off;

    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    logic idle_s;
    assign idle_s = (q.state == NVC_IDLE);

    a_busy_state: assert property (
        busy_o |-> q.cnt <= 16'(PROG_CYCLES - 1))
        else $error("busy outlasts programming time");

    a_row_guard: assert property (
        (wr_i && eep_ok && idle_s && q.arm && !row_ok) |=>
        $stable(lat_mask) && $stable(lat_data))
        else $error("write to other row reached latches");

    a_row_load: assert property (
        (wr_i && eep_ok && idle_s && q.arm && row_ok) |=> lat_vld)
        else $error("armed write not latched");

    a_abandon: assert property (
        (ctrl_wr && idle_s && q.arm && !wdata_i[2]) |=> !lat_vld && !busy_o)
        else $error("disarm did not abandon row");

    a_halt_off: assert property (
        halt_i |=> off_o)
        else $error("halt did not disable");

    a_busy_hold: assert property (
        $rose(busy_o) |-> busy_o [*8])
        else $error("busy dropped too early");

    a_start_gate: assert property (
        (ctrl_wr && idle_s && !(wdata_i[3] && wdata_i[0] && wdata_i[2] && q.arm))
        |=> !busy_o && !q.start)
        else $error("parallel start without enable and arm");

    a_arm_ends: assert property (
        (prog_done && q.par) |=> !q.arm && !q.start && !busy_o)
        else $error("arm or start not cleared at cycle end");

    a_ctrl_locked: assert property (
        (ctrl_wr && !idle_s && !prog_done) |=>
        $stable(q.en) && $stable(q.arm) && $stable(q.standby))
        else $error("control changed while busy");

    a_no_enable: assert property (
        (wr_i && eep_sel && idle_s && !q.en && !ctrl_wr) |=> !busy_o)
        else $error("write cycle started without enable");

    a_byte_start: assert property (
        (wr_i && eep_ok && idle_s && q.en && !q.arm) |=> busy_o && !q.par)
        else $error("byte write did not start cycle");

    a_busy_abort: assert property (
        (rd_i && eep_sel && !idle_s && addr_i != `NVC_CTRL_ADDR) |=>
        rhit_o && rdata_o == 8'hFF)
        else $error("read while busy not aborted");

    a_ctrl_read: assert property (
        (rd_i && addr_i == `NVC_CTRL_ADDR) |=>
        rdata_o[7:2] == 6'h00 && !rdata_o[0] && rdata_o[1] == $past(busy_o))
        else $error("control read value wrong");

    a_arm_clears: assert property (
        (ctrl_wr && idle_s && wdata_i[2] && !q.arm) |=> lat_mask == 8'h00 && !lat_vld)
        else $error("row latches not cleared on arm");

    a_off_state: assert property (
        (ctrl_wr && idle_s && wdata_i[6]) |=> off_o)
        else $error("standby did not disable");

    c_byte_cycle: cover property (!q.par && prog_done);
    c_par_cycle: cover property (q.par && prog_done && lat_mask != 8'h00);
    c_abandon: cover property (ctrl_wr && idle_s && q.arm && !wdata_i[2]);
    c_wrong_row: cover property (wr_i && eep_ok && q.arm && !row_ok);
    c_halt_write: cover property (halt_i && wr_i && eep_sel);

endmodule

`default_nettype wire

// File: nvc_ctrl_test.sv
// Self-checking bench for the data EEPROM write controller
// Assumes nvc_ctrl with a short programming time and the CPU model
`timescale 1ns/1ps
`default_nettype none

module nvc_ctrl_test;
    localparam int PROG = 8;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic halt_i = 1'b0;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic rhit;
    logic busy;
    logic off;
    int bad_count = 0;
    int samples_checked = 0;
    int busy_n = 0;
    int cycles = 0;
    logic [7:0] ra [7] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1F, 8'h08};
    logic [7:0] rv [7] = '{8'hA1, 8'hFF, 8'hA2, 8'hA3, 8'hFF, 8'hFF, 8'hFF};

    nvc_ctrl #(.PROG_CYCLES(PROG)) i_nvc_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .halt_i(halt_i), .rdata_o(rdata),
        .rhit_o(rhit), .busy_o(busy), .off_o(off));

    nvc_cpu_model i_nvc_cpu_model (
        .clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
        .rd_o(rd), .rdata_i(rdata), .rhit_i(rhit), .busy_i(busy));

    always #2.5 clk_i = ~clk_i;

    always @(negedge clk_i)
    begin
        if (busy === 1'b1)
            busy_n = busy_n + 1;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 1500)
        begin
            bad_count = bad_count + 1;
            tally_and_finish();
        end
    end

    task automatic check8(input string what, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check1(input string what, input logic e, input logic g);
        check8(what, {7'h00, e}, {7'h00, g});
    endtask

    task automatic wr_acc(input logic [7:0] a, input logic [7:0] d);
        i_nvc_cpu_model.cpu_write(a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic h, input logic [7:0] d);
        i_nvc_cpu_model.cpu_read(a);
        check1("read hit", h, i_nvc_cpu_model.seen_hit);
        check8("read data", d, i_nvc_cpu_model.seen_data);
    endtask

    task automatic prog_chk(input int n);
        repeat (PROG + 3) @(negedge clk_i);
        check8("busy cycles", n[7:0], busy_n[7:0]);
        busy_n = 0;
    endtask

    initial
    begin
        repeat (2) @(negedge clk_i);
        rst_i = 1'b0;
        check1("busy", 1'b0, busy);
        rd_chk(8'hEA, 1'b1, 8'h00);
        rd_chk(8'h05, 1'b0, 8'h00);
        wr_acc(8'hE8, 8'h01);
        wr_acc(8'h05, 8'h5A);
        prog_chk(0);
        rd_chk(8'h05, 1'b1, 8'hFF);
        wr_acc(8'hEA, 8'h01);
        wr_acc(8'h05, 8'h5A);
        rd_chk(8'hEA, 1'b1, 8'h02);
        wr_acc(8'hEA, 8'h00);
        wr_acc(8'h06, 8'h33);
        prog_chk(PROG);
        rd_chk(8'h06, 1'b1, 8'hFF);
        rd_chk(8'h05, 1'b1, 8'h5A);
        i_nvc_cpu_model.wait_idle();
        wr_acc(8'h06, 8'h33);
        rd_chk(8'h05, 1'b1, 8'hFF);
        prog_chk(PROG);
        rd_chk(8'h06, 1'b1, 8'h33);
        wr_acc(8'hEA, 8'h09);
        wr_acc(8'hEA, 8'h05);
        prog_chk(0);
        wr_acc(8'h18, 8'hA1);
        wr_acc(8'h1A, 8'hA2);
        wr_acc(8'h1B, 8'hA3);
        wr_acc(8'h08, 8'h77);
        wr_acc(8'hEA, 8'h0D);
        prog_chk(PROG);
        for (int i = 0; i < 7; i++)
            rd_chk(ra[i], 1'b1, rv[i]);
        wr_acc(8'hEA, 8'h09);
        prog_chk(0);
        wr_acc(8'hEA, 8'h05);
        prog_chk(0);
        wr_acc(8'h20, 8'h11);
        wr_acc(8'hEA, 8'h01);
        wr_acc(8'hEA, 8'h09);
        prog_chk(0);
        wr_acc(8'hEA, 8'h05);
        wr_acc(8'h21, 8'h22);
        wr_acc(8'hEA, 8'h0D);
        prog_chk(PROG);
        rd_chk(8'h20, 1'b1, 8'hFF);
        rd_chk(8'h21, 1'b1, 8'h22);
        wr_acc(8'hEA, 8'h41);
        @(negedge clk_i);
        check1("off", 1'b1, off);
        wr_acc(8'h30, 8'h44);
        prog_chk(0);
        rd_chk(8'h05, 1'b1, 8'hFF);
        wr_acc(8'hEA, 8'h01);
        @(negedge clk_i);
        check1("off", 1'b0, off);
        halt_i = 1'b1;
        repeat (2) @(negedge clk_i);
        check1("off", 1'b1, off);
        wr_acc(8'h30, 8'h44);
        prog_chk(0);
        rd_chk(8'h05, 1'b1, 8'hFF);
        halt_i = 1'b0;
        repeat (2) @(negedge clk_i);
        rd_chk(8'h30, 1'b1, 8'hFF);
        rd_chk(8'h05, 1'b1, 8'h5A);
        tally_and_finish();
    end
endmodule

`default_nettype wire

// File: nvc_defines.svh
// Constants for the data EEPROM write controller
// Assumes an 8-bit CPU data space and a 200 MHz system clock
`ifndef NVC_DEFINES_SVH
`define NVC_DEFINES_SVH

// Data-space addresses
`define NVC_CTRL_ADDR 8'hEA
`define NVC_BANK_ADDR 8'hE8
`define NVC_WIN_TOP 2'h0

// Control register fields
`define NVC_BIT_EN 0
`define NVC_BIT_BUSY 1
`define NVC_BIT_ARM 2
`define NVC_BIT_START 3
`define NVC_BIT_STBY 6
`define NVC_CTRL_RESET 8'h00

// Bank select field
`define NVC_BIT_PAGE0 0

// Array contents
`define NVC_ERASED 8'hFF
`define NVC_BYTES 64
`define NVC_ROW_BYTES 8

// Programming time
`define NVC_CLK_PERIOD_NS 5
`define NVC_PROG_TIME_NS 10000
`define NVC_CNT_W 16

`endif

// File: nvc_pkg.sv
// Types for the data EEPROM write controller
// Assumes nvc_defines.svh is on the include path
package nvc_pkg;

    typedef enum logic [0:0] {
        NVC_IDLE = 1'b0,
        NVC_PROG = 1'b1
    } nvc_state_t;

    typedef logic [63:0][7:0] nvc_mem_t;

    typedef struct packed {
        logic vld;
        logic [2:0] row;
        logic [7:0][7:0] data;
        logic [7:0] mask;
    } nvc_lat_t;

    typedef struct packed {
        nvc_state_t state;
        logic en;
        logic arm;
        logic start;
        logic standby;
        logic page0;
        logic par;
        logic [5:0] saddr;
        logic [7:0] sdata;
        logic [15:0] cnt;
        logic busy;
        logic off;
        logic rhit;
        logic [7:0] rdata;
    } nvc_ctl_t;

endpackage

// File: nvc_row_latch.sv
// Volatile row latches for parallel programming
// Assumes the controller only loads bytes that belong to the latched row
`timescale 1ns/1ps
`default_nettype none

module nvc_row_latch
    import nvc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Control
    input wire logic clr_i,
    input wire logic ld_i,
    input wire logic [5:0] addr_i,
    input wire logic [7:0] data_i,
    // Contents
    output logic vld_o,
    output logic [2:0] row_o,
    output logic [63:0] data_o,
    output logic [7:0] mask_o
);

    nvc_lat_t q;
    nvc_lat_t d;
    wire logic [63:0] byte_nxt;
    wire logic [7:0] mask_nxt;

    // Per-byte load of data and written mask
    for (genvar b = 0; b < 8; b++)
    begin : g_byte
        wire logic hit;
        assign hit = ld_i && (addr_i[2:0] == 3'(b));
        assign byte_nxt[b * 8 +: 8] = hit ? data_i : q.data[b];
        assign mask_nxt[b] = hit || q.mask[b];
    end

    always_comb
    begin
        d = q;
        if (clr_i)
        begin
            d = '0;
        end
        else if (ld_i)
        begin
            d.vld = 1'b1;
            d.row = addr_i[5:3];
            d.data = byte_nxt;
            d.mask = mask_nxt;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign vld_o = q.vld;
    assign row_o = q.row;
    assign data_o = q.data;
    assign mask_o = q.mask;

endmodule

`default_nettype wire
